// ===== pkg/pcirq_pkg.sv
/*
 * Constants and carrier types for the PC Card socket interrupt and
 * general control block.
 * Assumes one host clock and two 16-bit PC Card sockets.
 */
package pcirq_pkg;
    localparam int NUM_SOCKETS = 2;
    localparam int NUM_IRQ = 16;
    localparam int SEL_W = 4;
    // Legacy index of each socket copy
    localparam logic [11:0] IDX_SOCK_A = 12'h003;
    localparam logic [11:0] IDX_SOCK_B = 12'h043;
    // Memory-mapped offset from each socket register base
    localparam logic [11:0] MEM_OFF_CTRL = 12'h803;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] RDATA_UNMAPPED = 8'h00;
    // Field positions
    localparam int RING_EN_BIT = 7;
    localparam int CARD_RUN_BIT = 6;
    localparam int CARD_KIND_BIT = 5;
    localparam int CSC_ROUTE_BIT = 4;
    localparam int FSEL_LSB = 0;
    // Select encodings
    localparam logic [3:0] SEL_NONE = 4'h0;
    localparam logic [3:0] SEL_SMI = 4'h2;
    localparam logic [15:0] IRQ_ONE = 16'h0001;
    localparam logic [15:0] IRQ_NONE = 16'h0000;

    typedef struct packed {
        logic mem_space;
        logic socket;
        logic [11:0] offset;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } pcirq_acc_t;
endpackage

// ===== hdl/pcirq_socket_ctl.sv
/*
 * One socket copy of the interrupt and general control register and
 * its routing decode.
 * Assumes synchronised card inputs and a write strobe from the decoder.
 */
`timescale 1ns/10ps
`default_nettype none
module pcirq_socket_ctl (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic wr_en,
    input wire logic [7:0] wdata,
    input wire logic card_is_16bit,
    input wire logic func_req,
    input wire logic csc_event,
    input wire logic [3:0] status_change_irq_select,
    input wire logic diag_csc_enable,
    input wire logic ring_pin,
    input wire logic battery_dead,
    output logic [7:0] ctrl,
    output logic card_reset,
    output logic [15:0] irq_vec,
    output logic smi,
    output logic pci_int,
    output logic ring_indicate,
    output logic csc_bit0_src
);
    logic [7:0] ctrl_reg;
    logic [3:0] fsel;
    logic ring_enable;
    logic card_kind;
    logic status_change_pci_route;
    logic func_active;
    logic func_pci;
    logic func_smi;
    logic [15:0] func_irq;
    logic compat_pci;
    logic csc_pci;
    logic csc_via_sel;
    logic csc_smi;
    logic [15:0] csc_irq;

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_reg <= pcirq_pkg::CTRL_RESET;
        end else if (wr_en) begin
            ctrl_reg <= wdata;
        end
    end

    assign ctrl = ctrl_reg;
    assign fsel = ctrl_reg[pcirq_pkg::FSEL_LSB +: pcirq_pkg::SEL_W];
    assign ring_enable = ctrl_reg[pcirq_pkg::RING_EN_BIT];
    assign card_kind = ctrl_reg[pcirq_pkg::CARD_KIND_BIT];
    assign status_change_pci_route = ctrl_reg[pcirq_pkg::CSC_ROUTE_BIT];

    // Card reset held while the run bit is low, 16-bit cards only
    assign card_reset = card_is_16bit & ~ctrl_reg[pcirq_pkg::CARD_RUN_BIT];
    assign ring_indicate = ring_enable & ring_pin;
    assign csc_bit0_src = ring_enable ? ring_pin : battery_dead;

    // Functional interrupts are only taken from I/O cards
    assign func_active = func_req & card_kind;
    assign func_pci = func_active & (fsel == pcirq_pkg::SEL_NONE);
    assign func_smi = func_active & (fsel == pcirq_pkg::SEL_SMI);
    assign func_irq = (func_active && fsel != pcirq_pkg::SEL_NONE && fsel != pcirq_pkg::SEL_SMI) ?
        (pcirq_pkg::IRQ_ONE << fsel) : pcirq_pkg::IRQ_NONE;

    // Status change routing
    assign compat_pci = status_change_pci_route | (fsel == pcirq_pkg::SEL_NONE);
    assign csc_pci = csc_event & ((status_change_irq_select == pcirq_pkg::SEL_NONE) ?
        diag_csc_enable : compat_pci);
    assign csc_via_sel = csc_event & (status_change_irq_select != pcirq_pkg::SEL_NONE) & ~compat_pci;
    assign csc_smi = csc_via_sel & (status_change_irq_select == pcirq_pkg::SEL_SMI);
    assign csc_irq = (csc_via_sel && status_change_irq_select != pcirq_pkg::SEL_SMI) ?
        (pcirq_pkg::IRQ_ONE << status_change_irq_select) : pcirq_pkg::IRQ_NONE;

    assign irq_vec = func_irq | csc_irq;
    assign smi = func_smi | csc_smi;
    assign pci_int = func_pci | csc_pci;
endmodule // pcirq_socket_ctl
`default_nettype wire

// ===== hdl/pcirq_ctrl_top.sv
/*
 * Interrupt and general control for two 16-bit PC Card sockets:
 * register access by legacy index or memory-mapped offset, card reset,
 * card kind, ring indicate and interrupt routing.
 * Assumes card pins are asynchronous; status inputs are on mclk.
 */
//
// Contract
// - Ring enable bit gates ring indicate on the battery/ring pin; off at reset.
// - Card reset output asserted while reset bit is zero, released when one.
// - Card reset bit acts on 16-bit cards only, never 32-bit cards.
// - Card kind bit zero means memory card, one means I/O card.
// - Route bit one sends status changes to PCI when status select is nonzero, else status select field decides.
// - Four-bit functional select routes I/O card interrupts; resets to zero.
// - Functional select zero means PCI interrupt; ORed with the route bit.
// - Each socket owns an 8-bit copy at index 03h/43h and base plus 803h.
// - Status select zero routes to PCI only when diagnostic enable set.
// - With ring enabled, status bit 0 reports ring state, not battery dead.
`timescale 1ns/10ps
`default_nettype none
module pcirq_ctrl_top #(
    parameter int NUM_IRQ = pcirq_pkg::NUM_IRQ
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire pcirq_pkg::pcirq_acc_t acc,
    output logic [7:0] rdata,
    input wire logic [1:0] card_is_16bit,
    input wire logic [1:0] card_func_irq_pin,
    input wire logic [1:0] battery_detect1_ring_pin,
    input wire logic [1:0] csc_event,
    input wire logic [1:0] battery_dead,
    input wire logic [1:0][3:0] status_change_irq_select,
    input wire logic [1:0] diag_csc_enable,
    output logic [1:0] card_reset,
    output logic [1:0] card_kind,
    output logic [NUM_IRQ-1:0] host_irq,
    output logic smi_out,
    output logic [1:0] pci_int,
    output logic [1:0] ring_indicate,
    output logic [1:0] csc_bit0_status
);
    logic [1:0] ring_meta;
    logic [1:0] ring_sync;
    logic [1:0] func_meta;
    logic [1:0] func_sync;
    logic [1:0] hit;
    logic [1:0][7:0] ctrl;
    logic [1:0] rst_c;
    logic [1:0][15:0] irq_c;
    logic [1:0] smi_c;
    logic [1:0] pci_c;
    logic [1:0] ring_c;
    logic [1:0] bit0_c;
    logic [7:0] rdata_next;
    logic [7:0] rdata_reg;
    logic [15:0] irq_next;

    // Two-stage synchronisers for card pins
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            ring_meta <= 2'h0;
            ring_sync <= 2'h0;
            func_meta <= 2'h0;
            func_sync <= 2'h0;
        end else begin
            ring_meta <= battery_detect1_ring_pin;
            ring_sync <= ring_meta;
            func_meta <= card_func_irq_pin;
            func_sync <= func_meta;
        end
    end

    // Address decode: legacy index or socket memory window
    assign hit[0] = acc.mem_space ? (acc.offset == pcirq_pkg::MEM_OFF_CTRL && !acc.socket) :
        (acc.offset == pcirq_pkg::IDX_SOCK_A);
    assign hit[1] = acc.mem_space ? (acc.offset == pcirq_pkg::MEM_OFF_CTRL && acc.socket) :
        (acc.offset == pcirq_pkg::IDX_SOCK_B);

    genvar s;
    generate
        for (s = 0; s < pcirq_pkg::NUM_SOCKETS; s++) begin : g_sock
            pcirq_socket_ctl u_sock (
                .mclk(mclk),
                .sys_rst(sys_rst),
                .wr_en(acc.wr & hit[s]),
                .wdata(acc.wdata),
                .card_is_16bit(card_is_16bit[s]),
                .func_req(func_sync[s]),
                .csc_event(csc_event[s]),
                .status_change_irq_select(status_change_irq_select[s]),
                .diag_csc_enable(diag_csc_enable[s]),
                .ring_pin(ring_sync[s]),
                .battery_dead(battery_dead[s]),
                .ctrl(ctrl[s]),
                .card_reset(rst_c[s]),
                .irq_vec(irq_c[s]),
                .smi(smi_c[s]),
                .pci_int(pci_c[s]),
                .ring_indicate(ring_c[s]),
                .csc_bit0_src(bit0_c[s])
            );
        end
    endgenerate

    assign rdata_next = !acc.rd ? rdata_reg : hit[0] ? ctrl[0] : hit[1] ? ctrl[1] : pcirq_pkg::RDATA_UNMAPPED;
    assign irq_next = irq_c[0] | irq_c[1];

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            rdata_reg <= pcirq_pkg::RDATA_UNMAPPED;
            card_reset <= 2'h0;
            card_kind <= 2'h0;
            host_irq <= '0;
            smi_out <= 1'b0;
            pci_int <= 2'h0;
            ring_indicate <= 2'h0;
            csc_bit0_status <= 2'h0;
        end else begin
            rdata_reg <= rdata_next;
            card_reset <= rst_c;
            card_kind <= {ctrl[1][pcirq_pkg::CARD_KIND_BIT], ctrl[0][pcirq_pkg::CARD_KIND_BIT]};
            host_irq <= irq_next[NUM_IRQ-1:0];
            smi_out <= |smi_c;
            pci_int <= pci_c;
            ring_indicate <= ring_c;
            csc_bit0_status <= bit0_c;
        end
    end

    assign rdata = rdata_reg;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    property p_ring_gate;
        ring_indicate[0] == $past(ctrl[0][7] & ring_sync[0]);
    endproperty
    a_ring_gate: assert property (p_ring_gate) else $error("ring indicate not gated by enable");

    property p_reset_bit;
        (card_is_16bit[0] && !ctrl[0][6]) |=> card_reset[0];
    endproperty
    a_reset_bit: assert property (p_reset_bit) else $error("card reset not asserted");

    property p_reset_32bit;
        !card_is_16bit[1] |=> !card_reset[1];
    endproperty
    a_reset_32bit: assert property (p_reset_32bit) else $error("card reset on 32-bit card");

    property p_kind;
        (acc.wr && hit[0]) |=> ##1 card_kind[0] == $past(acc.wdata[5], 2);
    endproperty
    a_kind: assert property (p_kind) else $error("card kind not following write");

    property p_csc_route;
        (csc_event[0] && status_change_irq_select[0] != 4'h0 && ctrl[0][4]) |=> pci_int[0];
    endproperty
    a_csc_route: assert property (p_csc_route) else $error("status change not routed to PCI");

    property p_zero_pci;
        (ctrl[0][5] && func_sync[0] && ctrl[0][3:0] == 4'h0 && !ctrl[1][5] && !csc_event[1])
            |=> pci_int[0] && host_irq == 16'h0000;
    endproperty
    a_zero_pci: assert property (p_zero_pci) else $error("select zero not routed to PCI");

    property p_smi;
        (ctrl[0][5] && func_sync[0] && ctrl[0][3:0] == 4'h2) |=> smi_out;
    endproperty
    a_smi: assert property (p_smi) else $error("SMI code not routed");

    property p_irq_code;
        (ctrl[1][5] && func_sync[1] && ctrl[1][3:0] == 4'h9) |=> host_irq[9];
    endproperty
    a_irq_code: assert property (p_irq_code) else $error("IRQ9 code not routed");

    property p_irq_other;
        (ctrl[0][5] && func_sync[0] && ctrl[0][3:0] == 4'hF) |=> host_irq[15];
    endproperty
    a_irq_other: assert property (p_irq_other) else $error("code not routed to its IRQ");

    property p_memory_card;
        (!ctrl[0][5] && !ctrl[1][5] && csc_event == 2'h0) |=> host_irq == 16'h0000 && !smi_out;
    endproperty
    a_memory_card: assert property (p_memory_card) else $error("memory card raised interrupt");

    property p_diag;
        (csc_event[0] && status_change_irq_select[0] == 4'h0 && !diag_csc_enable[0] && !func_sync[0]) |=> !pci_int[0];
    endproperty
    a_diag: assert property (p_diag) else $error("status change reached PCI without enable");

    property p_bit0;
        csc_bit0_status[0] == $past(ctrl[0][7] ? ring_sync[0] : battery_dead[0]);
    endproperty
    a_bit0: assert property (p_bit0) else $error("status bit 0 source wrong");

    property p_read_b;
        (acc.rd && hit[1] && !hit[0]) |=> rdata == $past(ctrl[1]);
    endproperty
    a_read_b: assert property (p_read_b) else $error("socket B read data wrong");
endmodule // pcirq_ctrl_top
`default_nettype wire

// ===== verification/pcirq_card_model.sv
/*
 * Model of the PC Cards in both sockets and their interrupt pins.
 * Assumes the bench sets the card's requests; pins follow them
 * after a delay unrelated to the host clock.
 */
`timescale 1ns/10ps
`default_nettype none
module pcirq_card_model #(
    parameter logic [1:0] KIND16 = 2'h1
) (
    input wire logic [1:0] func_req,
    input wire logic [1:0] ring_req,
    output wire logic [1:0] card_is_16bit,
    output wire logic [1:0] card_func_irq_pin,
    output wire logic [1:0] battery_detect1_ring_pin
);
    // Socket A holds a 16-bit card, socket B a 32-bit card
    assign card_is_16bit = KIND16;
    assign #7 card_func_irq_pin = func_req;
    assign #7 battery_detect1_ring_pin = ring_req;
endmodule // pcirq_card_model
`default_nettype wire

// ===== verification/pcirq_ctrl_top_tb_top.sv
/*
 * Self-checking bench for the socket interrupt and general control.
 * Assumes a 20 MHz mclk and the card model on the socket pins.
 */
`timescale 1ns/10ps
`default_nettype none
module pcirq_ctrl_top_tb_top;
    typedef struct packed {
        logic [7:0] ctrl;
        logic f;
        logic d;
        logic smi;
        logic pci;
        logic [3:0] ss;
        logic [15:0] irq;
    } pcirq_row_t;
    // ctrl, flags {func, diag, smi, pci}, status select, host irq
    pcirq_row_t rows [16] = '{32'h21_8_0_0002, 32'h22_A_0_0000, 32'h24_8_0_0010, 32'h25_8_0_0020,
        32'h28_8_0_0100, 32'h29_8_0_0200, 32'h23_8_0_0008, 32'h2F_8_0_8000, 32'h20_9_0_0000,
        32'h09_8_0_0000, 32'h10_1_5_0000, 32'h05_0_5_0020, 32'h05_2_2_0000, 32'h00_1_5_0000,
        32'h15_0_0_0000, 32'h05_5_0_0000};
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    pcirq_pkg::pcirq_acc_t acc = '0;
    logic [7:0] rdata;
    wire logic [1:0] card_is_16bit;
    wire logic [1:0] card_func_irq_pin;
    wire logic [1:0] battery_detect1_ring_pin;
    logic [1:0] csc_event = 2'h0;
    logic [1:0] battery_dead = 2'h0;
    logic [1:0][3:0] status_change_irq_select = '0;
    logic [1:0] diag_csc_enable = 2'h0;
    logic [1:0] func_req = 2'h0;
    logic [1:0] ring_req = 2'h0;
    logic [1:0] card_reset, card_kind, pci_int, ring_indicate, csc_bit0_status;
    logic [15:0] host_irq;
    logic smi_out;
    int err_count = 0;
    int n_tests = 0;
    int cyc = 0;

    always #25 mclk = ~mclk;

    pcirq_ctrl_top u_pcirq_ctrl_top (.mclk(mclk), .sys_rst(sys_rst), .acc(acc), .rdata(rdata),
        .card_is_16bit(card_is_16bit), .card_func_irq_pin(card_func_irq_pin),
        .battery_detect1_ring_pin(battery_detect1_ring_pin), .csc_event(csc_event),
        .battery_dead(battery_dead), .status_change_irq_select(status_change_irq_select),
        .diag_csc_enable(diag_csc_enable), .card_reset(card_reset), .card_kind(card_kind),
        .host_irq(host_irq), .smi_out(smi_out), .pci_int(pci_int), .ring_indicate(ring_indicate),
        .csc_bit0_status(csc_bit0_status));
    pcirq_card_model u_pcirq_card_model (.func_req(func_req), .ring_req(ring_req),
        .card_is_16bit(card_is_16bit), .card_func_irq_pin(card_func_irq_pin),
        .battery_detect1_ring_pin(battery_detect1_ring_pin));

    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // One access cycle: request for one edge, then idle
    task automatic acc_go(input logic m, input logic s, input logic [11:0] o, input logic w,
        input logic [7:0] d);
        @(posedge mclk);
        acc <= '{mem_space: m, socket: s, offset: o, wr: w, rd: !w, wdata: d};
        @(posedge mclk);
        acc <= '0;
    endtask

    task automatic rd_chk(input logic m, input logic s, input logic [11:0] o, input logic [7:0] e);
        acc_go(m, s, o, 1'b0, 8'h00);
        #1;
        chk(16'(rdata), 16'(e));
    endtask

    task automatic wr_wait(input logic m, input logic s, input logic [11:0] o, input logic [7:0] d);
        acc_go(m, s, o, 1'b1, d);
        repeat (4) @(posedge mclk);
        #1;
    endtask

    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            err_count++;
            stop_test();
        end
    end

    initial begin
        repeat (8) @(posedge mclk);
        sys_rst <= 1'b0;
        rd_chk(1'b0, 1'b0, 12'h003, 8'h00);
        rd_chk(1'b0, 1'b0, 12'h043, 8'h00);
        chk(16'(card_reset), 16'h0001);
        chk(16'(card_kind), 16'h0000);
        chk(16'(ring_indicate), 16'h0000);
        $display("reset test done");
        for (int i = 0; i < 16; i++) begin
            @(posedge mclk);
            func_req[0] <= rows[i].f;
            csc_event[0] <= !rows[i].f;
            status_change_irq_select[0] <= rows[i].ss;
            diag_csc_enable[0] <= rows[i].d;
            wr_wait(1'b0, 1'b0, 12'h003, rows[i].ctrl);
            chk(host_irq, rows[i].irq);
            chk(16'(smi_out), 16'(rows[i].smi));
            chk(16'(pci_int[0]), 16'(rows[i].pci));
            rd_chk(1'b0, 1'b0, 12'h003, rows[i].ctrl);
            $display("row %0d done", i);
        end
        ring_req <= 2'h3;
        wr_wait(1'b1, 1'b0, 12'h803, 8'hE0);
        chk(16'(card_reset[0]), 16'h0000);
        chk(16'(card_kind[0]), 16'h0001);
        chk(16'(ring_indicate[0]), 16'h0001);
        chk(16'(csc_bit0_status[0]), 16'h0001);
        rd_chk(1'b0, 1'b0, 12'h003, 8'hE0);
        wr_wait(1'b0, 1'b0, 12'h003, 8'h60);
        chk(16'(ring_indicate[0]), 16'h0000);
        chk(16'(csc_bit0_status[0]), 16'h0000);
        $display("ring test done");
        @(posedge mclk);
        csc_event[1] <= 1'b1;
        diag_csc_enable[1] <= 1'b1;
        func_req[1] <= 1'b1;
        wr_wait(1'b0, 1'b0, 12'h043, 8'h69);
        chk(host_irq, 16'h0200);
        chk(16'(pci_int[1]), 16'h0001);
        chk(16'(card_reset), 16'h0000);
        wr_wait(1'b0, 1'b0, 12'h043, 8'h40);
        chk(16'(card_reset), 16'h0000);
        rd_chk(1'b1, 1'b1, 12'h803, 8'h40);
        wr_wait(1'b0, 1'b0, 12'h013, 8'hFF);
        rd_chk(1'b0, 1'b0, 12'h013, 8'h00);
        rd_chk(1'b0, 1'b0, 12'h003, 8'h60);
        rd_chk(1'b0, 1'b0, 12'h043, 8'h40);
        $display("socket and unmapped test done");
        stop_test();
    end
endmodule // pcirq_ctrl_top_tb_top
`default_nettype wire
